// [hdl/tpa_channel.sv]
// One trim channel: code selection, bus-written code and closed-loop code.
`timescale 1ns/1ps
module tpa_channel #(
   parameter int unsigned CODE_W = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [1:0] profile,
   input wire logic [1:0] mode,
   input wire logic [4*CODE_W-1:0] stored_codes,
   input wire logic bus_we,
   input wire logic [CODE_W-1:0] bus_wdata,
   input wire logic loop_step,
   input wire logic [1:0] cmp_result,
   input wire logic polarity,
   output logic [CODE_W-1:0] dac_code,
   output logic [CODE_W-1:0] bus_code,
   output logic [CODE_W-1:0] loop_code
);
   logic [CODE_W-1:0] bus_q;
   logic [CODE_W-1:0] loop_q;
   logic [CODE_W-1:0] dac_q;
   logic [CODE_W-1:0] dac_d;
   logic up;

   // =====================================================================
   // Volatile registers
   // =====================================================================
   // Bus-written code, writable at any time, bipolar zero after reset.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bus_q <= tpa_pkg::TPA_BIPOLAR_ZERO;
      end else if (bus_we) begin
         bus_q <= bus_wdata;
      end
   end

   // Polarity flips the step direction; saturate so the code never wraps.
   assign up = (cmp_result == tpa_pkg::TPA_CMP_UP) ^ polarity;

   // Closed-loop code steps once per interval; a bus write preloads it unless it falls in a loop_step cycle.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         loop_q <= tpa_pkg::TPA_BIPOLAR_ZERO;
      end else if (bus_we && !loop_step) begin
         loop_q <= bus_wdata;
      end else if (loop_step && cmp_result != tpa_pkg::TPA_CMP_EQ) begin
         if (up && loop_q != {CODE_W{1'b1}}) begin
            loop_q <= loop_q + 1'b1;
         end else if (!up && loop_q != '0) begin
            loop_q <= loop_q - 1'b1;
         end
      end
   end

   // =====================================================================
   // Profile and mode selection
   // =====================================================================
   // Profile selects stored code 1..3; profile 0 defers to the mode.
   always_comb begin
      dac_d = stored_codes[0 +: CODE_W];
      unique case (profile)
         2'b11: dac_d = stored_codes[3*CODE_W +: CODE_W];
         2'b10: dac_d = stored_codes[2*CODE_W +: CODE_W];
         2'b01: dac_d = stored_codes[1*CODE_W +: CODE_W];
         2'b00: begin
            if (mode == tpa_pkg::TPA_MODE_BUS) begin
               dac_d = bus_q;
            end else if (mode == tpa_pkg::TPA_MODE_LOOP) begin
               dac_d = loop_q;
            end else begin
               dac_d = stored_codes[0 +: CODE_W];
            end
         end
      endcase
   end

   // DAC code is registered, so a new selection shows one cycle later.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dac_q <= tpa_pkg::TPA_BIPOLAR_ZERO;
      end else begin
         dac_q <= dac_d;
      end
   end

   assign dac_code = dac_q;
   assign bus_code = bus_q;
   assign loop_code = loop_q;

   AST_PROFILE3: assert property (@(posedge clk) disable iff (reset)
      profile == 2'b11 |=> dac_q == $past(stored_codes[3*CODE_W +: CODE_W]))
      else $error("Profile 3 did not select stored code 3.");
   AST_BUS_WRITE: assert property (@(posedge clk) disable iff (reset)
      bus_we |=> bus_q == $past(bus_wdata))
      else $error("Bus-written code did not store the written value.");
   AST_LOOP_EQ: assert property (@(posedge clk) disable iff (reset)
      loop_step && !bus_we && cmp_result == tpa_pkg::TPA_CMP_EQ |=> $stable(loop_q))
      else $error("Closed-loop code moved on an equal comparison.");
endmodule

// [hdl/tpa_top.sv]
// Trim profile selection for eight channels and the monitor readout path.
// Operation
// - Attenuated result is multiplied by three.
// - Readout is 12 bits, 8 high, 4 low.
// - Command routes monitor input, latches result.
// - Selector reaches every monitor input.
// - Eight channels, four profile codes each.
// - One 2-bit profile shared by all.
// - Config bit picks profile 0 or logic.
// - Profiles 3,2,1 use stored codes 3,2,1.
// - Six 8-bit code registers per channel.
// - Profile 0 mode: stored, bus or loop.
// - Stored mode uses stored code 0.
// - Bus code volatile, writable, resets to 80H.
// - One closed-loop enable for all channels.
// - Loop code steps by comparison and polarity.
// - Two-bit rate sets 580 us to 18.5 ms.
// - Loop code resets to 80h, bus preloadable; code drops a bus preload that meets a loop step.
`timescale 1ns/1ps
module tpa_top #(
   parameter int unsigned NUM_CH = tpa_pkg::TPA_NUM_CH,
   parameter int unsigned CODE_W = tpa_pkg::TPA_CODE_W,
   parameter int unsigned INT0_CYC = tpa_pkg::TPA_INT0_CYC,
   parameter int unsigned INT1_CYC = tpa_pkg::TPA_INT1_CYC,
   parameter int unsigned INT2_CYC = tpa_pkg::TPA_INT2_CYC,
   parameter int unsigned INT3_CYC = tpa_pkg::TPA_INT3_CYC
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [1:0] profile_select,
   input wire logic closed_loop_enable,
   input wire logic profile_from_logic,
   input wire logic [2*NUM_CH-1:0] channel_mode,
   input wire logic [NUM_CH-1:0] channel_polarity,
   input wire logic [4*CODE_W*NUM_CH-1:0] stored_codes,
   input wire logic [1:0] update_rate,
   input wire logic [2*NUM_CH-1:0] loop_compare,
   input wire logic [NUM_CH-1:0] bus_code_we,
   input wire logic [CODE_W-1:0] bus_code_wdata,
   input wire logic measure_req,
   input wire logic [tpa_pkg::TPA_MON_W-1:0] measure_input,
   input wire logic measure_atten,
   input wire logic adc_done,
   input wire logic [tpa_pkg::TPA_ADC_W-1:0] adc_result,
   output logic [CODE_W*NUM_CH-1:0] dac_code,
   output logic [tpa_pkg::TPA_MON_W-1:0] monitor_input,
   output logic adc_start,
   output logic measure_busy,
   output logic [tpa_pkg::TPA_HIGH_W-1:0] readout_high,
   output logic [tpa_pkg::TPA_LOW_W-1:0] readout_low,
   output logic loop_tick
);
   logic [1:0] vps_s1_q;
   logic [1:0] vps_s2_q;
   logic cle_s1_q;
   logic cle_s2_q;
   logic [1:0] profile;
   logic [31:0] tick_cnt_q;
   logic [31:0] tick_lim;
   logic tick_q;
   logic atten_q;
   logic [tpa_pkg::TPA_READ_W-1:0] scaled;
   logic [tpa_pkg::TPA_READ_W-1:0] result_q;

   // =====================================================================
   // Synchronisers for the programmable-logic controls
   // =====================================================================
   // The profile and enable come from a slower logic fabric; two stages each.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         vps_s1_q <= 2'h0;
         vps_s2_q <= 2'h0;
         cle_s1_q <= 1'b0;
         cle_s2_q <= 1'b0;
      end else begin
         vps_s1_q <= profile_select;
         vps_s2_q <= vps_s1_q;
         cle_s1_q <= closed_loop_enable;
         cle_s2_q <= cle_s1_q;
      end
   end

   // Configuration bit chooses fixed profile 0 or the logic-driven value.
   assign profile = profile_from_logic ? vps_s2_q : 2'b00;

   // =====================================================================
   // Closed-loop update interval
   // =====================================================================
   // Interval in cycles per rate code; counts above 4096 are parameters.
   always_comb begin
      tick_lim = INT0_CYC;
      unique case (update_rate)
         2'b00: tick_lim = INT0_CYC;
         2'b01: tick_lim = INT1_CYC;
         2'b10: tick_lim = INT2_CYC;
         2'b11: tick_lim = INT3_CYC;
      endcase
   end

   // Counter runs only while closed-loop trimming is enabled.
   // Clearing the count on disable makes the first step a full interval after enable.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tick_cnt_q <= 32'h0;
         tick_q <= 1'b0;
      end else if (!cle_s2_q) begin
         tick_cnt_q <= 32'h0;
         tick_q <= 1'b0;
      end else if (tick_cnt_q >= tick_lim - 32'h1) begin
         tick_cnt_q <= 32'h0;
         tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h1;
         tick_q <= 1'b0;
      end
   end
   assign loop_tick = tick_q;

   // =====================================================================
   // Trim channels
   // =====================================================================
   // Each channel holds four stored codes, a bus code and a loop code.
   generate
      for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
         tpa_channel #(
            .CODE_W(CODE_W)
         ) u_ch (
            .clk(clk),
            .reset(reset),
            .profile(profile),
            .mode(channel_mode[2*i +: 2]),
            .stored_codes(stored_codes[4*CODE_W*i +: 4*CODE_W]),
            .bus_we(bus_code_we[i]),
            .bus_wdata(bus_code_wdata),
            .loop_step(tick_q),
            .cmp_result(loop_compare[2*i +: 2]),
            .polarity(channel_polarity[i]),
            .dac_code(dac_code[CODE_W*i +: CODE_W]),
            .bus_code(),
            .loop_code()
         );
      end
   endgenerate

   // =====================================================================
   // Measurement readout
   // =====================================================================
   // A request is taken at any time; a newer one restarts the conversion.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         monitor_input <= '0;
         atten_q <= 1'b0;
         adc_start <= 1'b0;
         measure_busy <= 1'b0;
      end else begin
         adc_start <= measure_req;
         if (measure_req) begin
            monitor_input <= measure_input;
            atten_q <= measure_atten;
            measure_busy <= 1'b1;
         end else if (adc_done) begin
            measure_busy <= 1'b0;
         end
      end
   end

   // One count is 2 mV either way: attenuated codes are tripled.
   assign scaled = atten_q ? 12'(adc_result) * 12'(tpa_pkg::TPA_ATTEN_FACTOR)
                           : 12'(adc_result);

   // Result is captured once per finished conversion and then held.
   // A done that meets a new request belongs to the abandoned conversion.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         result_q <= '0;
      end else if (adc_done && measure_busy && !measure_req) begin
         result_q <= scaled;
      end
   end
   assign readout_high = result_q[11:4];
   assign readout_low = result_q[3:0];

   // =====================================================================
   // Readout and selection checks
   // =====================================================================
   // These watch registered values, so each expects its effect one cycle on.
   AST_READ_HOLD: assert property (@(posedge clk) disable iff (reset)
      !adc_done |=> $stable(result_q))
      else $error("Readout changed without a completed conversion.");
   AST_ATTEN_X3: assert property (@(posedge clk) disable iff (reset)
      adc_done && measure_busy && !measure_req && atten_q
      |=> result_q == 12'($past(adc_result)) * 12'h3)
      else $error("Attenuated result was not tripled.");
   AST_PLAIN_RESULT: assert property (@(posedge clk) disable iff (reset)
      adc_done && measure_busy && !measure_req && !atten_q
      |=> result_q == 12'($past(adc_result)))
      else $error("Unattenuated result was not passed through.");
   AST_ROUTE: assert property (@(posedge clk) disable iff (reset)
      measure_req |=> monitor_input == $past(measure_input) && adc_start)
      else $error("Request did not route the monitor input.");
   AST_START_PULSE: assert property (@(posedge clk) disable iff (reset)
      !measure_req |=> !adc_start)
      else $error("Converter start issued without a request.");
   AST_REQ_ANYTIME: assert property (@(posedge clk) disable iff (reset)
      measure_req && measure_busy |=> measure_busy && adc_start)
      else $error("A request during a conversion was not taken.");
   AST_BUSY_CLEAR: assert property (@(posedge clk) disable iff (reset)
      adc_done && measure_busy && !measure_req |=> !measure_busy)
      else $error("Busy stayed high after the result was latched.");
   // Follows the whole path to channel 0, so a broken selector is caught too.
   AST_FIXED_P0: assert property (@(posedge clk) disable iff (reset)
      !profile_from_logic && channel_mode[1:0] == 2'b00
      |=> dac_code[CODE_W-1:0] == $past(stored_codes[CODE_W-1:0]))
      else $error("Fixed profile 0 did not select stored code 0.");
   AST_NO_TICK: assert property (@(posedge clk) disable iff (reset)
      !cle_s2_q |=> !tick_q)
      else $error("Loop step issued while closed loop disabled.");
endmodule

// [include/tpa_pkg.sv]
// Package with constants and types for the trim profile and measurement readout block.
package tpa_pkg;
   // =====================================================================
   // Widths
   // =====================================================================
   localparam int unsigned TPA_CODE_W = 8;
   localparam int unsigned TPA_ADC_W = 10;
   localparam int unsigned TPA_READ_W = 12;
   localparam int unsigned TPA_HIGH_W = 8;
   localparam int unsigned TPA_LOW_W = 4;
   localparam int unsigned TPA_NUM_CH = 8;
   localparam int unsigned TPA_NUM_MON = 12;
   localparam int unsigned TPA_MON_W = 4;
   // =====================================================================
   // Reset values and scaling
   // =====================================================================
   localparam logic [7:0] TPA_BIPOLAR_ZERO = 8'h80;
   localparam logic [1:0] TPA_ATTEN_FACTOR = 2'h3;
   localparam int unsigned TPA_MV_PER_COUNT = 2;
   // =====================================================================
   // Closed-loop update intervals
   // =====================================================================
   localparam int unsigned TPA_CLK_MHZ = 125;
   localparam int unsigned TPA_INT0_NS = 580000;
   localparam int unsigned TPA_INT1_NS = 1150000;
   localparam int unsigned TPA_INT2_NS = 9220000;
   localparam int unsigned TPA_INT3_NS = 18500000;
   localparam int unsigned TPA_INT0_CYC = TPA_INT0_NS * TPA_CLK_MHZ / 1000;
   localparam int unsigned TPA_INT1_CYC = TPA_INT1_NS * TPA_CLK_MHZ / 1000;
   localparam int unsigned TPA_INT2_CYC = TPA_INT2_NS * TPA_CLK_MHZ / 1000;
   localparam int unsigned TPA_INT3_CYC = TPA_INT3_NS * TPA_CLK_MHZ / 1000;
   // =====================================================================
   // Types
   // =====================================================================
   typedef enum logic [1:0] {
      TPA_MODE_STORED = 2'b00,
      TPA_MODE_BUS = 2'b01,
      TPA_MODE_LOOP = 2'b10
   } tpa_mode_t;
   typedef enum logic [1:0] {
      TPA_CMP_EQ = 2'b00,
      TPA_CMP_UP = 2'b01,
      TPA_CMP_DOWN = 2'b10
   } tpa_cmp_t;
endpackage

// [test/tpa_adc_model.sv]
// Behavioural converter that answers start pulses from the readout path.
`timescale 1ns/1ps
module tpa_adc_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic adc_start,
   input wire logic [3:0] monitor_input,
   input wire logic slow,
   output logic adc_done,
   output logic [9:0] adc_result
);
   logic [5:0] cnt_q;
   logic [3:0] mon_q;
   // =====================================================================
   // Conversion timing
   // =====================================================================
   // A new start restarts the conversion; the result bus toggles outside the done cycle.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_q <= 6'h00;
         mon_q <= 4'h0;
         adc_done <= 1'b0;
         adc_result <= 10'h000;
      end else begin
         adc_done <= 1'b0;
         adc_result <= ~adc_result;
         if (adc_start) begin
            cnt_q <= slow ? 6'h14 : 6'h03;
            mon_q <= monitor_input;
         end else if (cnt_q != 6'h00) begin
            cnt_q <= cnt_q - 6'h01;
            if (cnt_q == 6'h01) begin
               adc_done <= 1'b1;
               adc_result <= {mon_q, 6'h2D};
            end
         end
      end
   end
endmodule

// [test/trim_profile_and_adc_readout_tb.sv]
// Self-checking bench for the trim profile selection and readout path.
`timescale 1ns/1ps
module trim_profile_and_adc_readout_tb;
   logic clk = 1'b0, reset = 1'b1, cle = 1'b0, pfl = 1'b0, req = 1'b0, atten = 1'b0;
   logic slow = 1'b0, done, start, busy, tick;
   logic [1:0] psel = 2'h0, rate = 2'h0;
   logic [15:0] mode = 16'h0000, cmp = 16'h0000;
   logic [7:0] pol = 8'h00, we = 8'h00, wdata = 8'h00, rd_high;
   logic [255:0] stored;
   logic [3:0] min = 4'h0, mon, rd_low;
   logic [9:0] res;
   logic [63:0] dac;
   int n_errors = 0, cmp_count = 0;
   always #4 clk = ~clk;
   tpa_top #(.INT0_CYC(10), .INT1_CYC(20), .INT2_CYC(30), .INT3_CYC(40)) dut_u (
      .clk(clk), .reset(reset), .profile_select(psel), .closed_loop_enable(cle),
      .profile_from_logic(pfl), .channel_mode(mode), .channel_polarity(pol),
      .stored_codes(stored), .update_rate(rate), .loop_compare(cmp), .bus_code_we(we),
      .bus_code_wdata(wdata), .measure_req(req), .measure_input(min),
      .measure_atten(atten), .adc_done(done), .adc_result(res), .dac_code(dac),
      .monitor_input(mon), .adc_start(start), .measure_busy(busy),
      .readout_high(rd_high), .readout_low(rd_low), .loop_tick(tick));
   tpa_adc_model adc_u (.clk(clk), .reset(reset), .adc_start(start),
      .monitor_input(mon), .slow(slow), .adc_done(done), .adc_result(res));
   // =====================================================================
   // Shared tasks
   // =====================================================================
   task automatic close_out();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(logic [11:0] got, logic [11:0] exp, string what);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Checks each channel against stored code k, or base plus index (k = -1), or base (k = -2).
   task automatic chk_all(int k, logic [7:0] base);
      for (int i = 0; i < 8; i++)
         chk(12'(dac[8*i +: 8]), (k < -1) ? 12'(base) :
             (k < 0) ? 12'(base + 8'(i)) : 12'(16 * i + k), "dac");
   endtask
   task automatic wait_tick();
      for (int n = 0; n < 200 && tick !== 1'b1; n++) cyc(1);
      if (tick !== 1'b1) chk(12'h000, 12'h001, "tick");
   endtask
   // One measurement request; with twice set, a second request on input b restarts it on the next cycle.
   task automatic measure(logic [3:0] a, logic [3:0] b, logic att, bit twice);
      logic [11:0] exp;
      min = a;
      atten = att;
      req = 1'b1;
      cyc(1);
      chk({10'h000, start, busy}, 12'h003, "start busy");
      min = b;
      req = twice;
      cyc(1);
      req = 1'b0;
      for (int n = 0; n < 60 && busy !== 1'b0; n++) cyc(1);
      chk(12'(busy), 12'h000, "busy clear");
      exp = att ? 12'({b, 6'h2D} * 3) : {2'h0, b, 6'h2D};
      chk({rd_high, rd_low}, exp, "readout");
      chk(12'(mon), 12'(b), "mux");
   endtask
   // =====================================================================
   // Test sequence
   // =====================================================================
   initial begin
      for (int i = 0; i < 8; i++)
         for (int k = 0; k < 4; k++) stored[32 * i + 8 * k +: 8] = 8'(16 * i + k);
      mode = 16'h5555;
      cyc(20);
      chk_all(-2, 8'h80);
      reset = 1'b0;
      cyc(2);
      chk_all(-2, 8'h80);
      chk({rd_high, rd_low}, 12'h000, "reset readout");
      mode = 16'hAAAA;
      cyc(2);
      chk_all(-2, 8'h80);
      mode = 16'hC000;
      pfl = 1'b1;
      for (int k = 3; k >= 0; k--) begin
         psel = 2'(k);
         cyc(4);
         chk_all(k, 8'h00);
      end
      psel = 2'h3;
      pfl = 1'b0;
      cyc(4);
      chk_all(0, 8'h00);
      mode = 16'h5555;
      for (int i = 0; i < 8; i++) begin
         we = 8'h01 << i;
         wdata = 8'hC0 + 8'(i);
         cyc(1);
      end
      we = 8'h00;
      cyc(2);
      chk_all(-1, 8'hC0);
      mode = 16'hAAAA;
      cyc(2);
      chk_all(-1, 8'hC0);
      cmp = 16'h00A5;
      pol = 8'h0A;
      cle = 1'b1;
      wait_tick();
      cyc(1);
      cmp = 16'h0000;
      cyc(2);
      chk(12'(dac[7:0]), 12'h0C1, "loop up");
      chk(12'(dac[15:8]), 12'h0C0, "loop up inverted");
      chk(12'(dac[23:16]), 12'h0C1, "loop down");
      chk(12'(dac[31:24]), 12'h0C4, "loop down inverted");
      chk(12'(dac[39:32]), 12'h0C4, "loop hold");
      for (int r = 0; r < 4; r++) begin
         int n;
         rate = 2'(r);
         wait_tick();
         cyc(1);
         wait_tick();
         cyc(1);
         for (n = 1; n < 100 && tick !== 1'b1; n++) cyc(1);
         chk(12'(n), 12'(10 * (r + 1)), "interval");
      end
      for (int m = 0; m < 12; m++) begin
         slow = m[0];
         measure(4'(m), 4'(m), m[1], 1'b0);
      end
      measure(4'h2, 4'hB, 1'b1, 1'b1);
      close_out();
   end
   initial begin
      #(4000 * 8);
      n_errors++;
      close_out();
   end
endmodule
